/* File: design/charger_limit_pkg.sv */
/*
  Constants for the charger supervisory block: register offsets, field
  positions, reset values, decode steps, fault and status codes, timings.
  Assumes a 100 MHz system clock.
*/
package charger_limit_pkg;
  // ==========================================================
  // Register map and fields
  localparam logic [7:0] FLOAT_OFS   = 8'h02;
  localparam logic [7:0] CURR_OFS    = 8'h04;
  localparam logic [7:0] FLOOR_OFS   = 8'h05;
  localparam logic [7:0] CEIL_OFS    = 8'h06;
  localparam int         FLOAT_LSB   = 2;
  localparam int         CURR_LSB    = 4;
  localparam int         LIMACT_BIT  = 3;
  localparam int         ICEIL_LSB   = 4;
  localparam logic [7:0] FLOAT_RST   = 8'h8c;
  localparam logic [7:0] CURR_RST    = 8'h00;
  localparam logic [7:0] FLOOR_RST   = 8'h00;
  localparam logic [7:0] CEIL_RST    = 8'h00;
  // ==========================================================
  // Decodes
  localparam logic [12:0] FLOOR_BASE_MV = 13'h1075;
  localparam logic [12:0] FLOOR_STEP_MV = 13'h0050;
  localparam logic [10:0] CURR_BASE_MA  = 11'h226;
  localparam logic [10:0] CURR_STEP_MA  = 11'h064;
  localparam logic [10:0] FOLD_MA       = 11'h226;
  localparam logic [3:0]  ICEIL_TOP     = 4'h9;
  localparam logic [3:0]  VCEIL_TOP     = 4'hc;
  localparam logic [5:0]  VMAX_BASE     = 6'h23;
  localparam logic [4:0]  PRE_LOW_MA    = 5'h0d;
  localparam logic [4:0]  PRE_HIGH_MA   = 5'h1e;
  // ==========================================================
  // Fault and status codes
  localparam logic [2:0] ERR_NONE  = 3'h0;
  localparam logic [2:0] ERR_OVP   = 3'h1;
  localparam logic [2:0] ERR_UV    = 3'h3;
  localparam logic [2:0] ERR_CELLV = 3'h4;
  localparam logic [2:0] ERR_HOT   = 3'h5;
  localparam logic [2:0] ERR_NOCEL = 3'h7;
  localparam logic [1:0] ST_READY  = 2'h0;
  localparam logic [1:0] ST_CHG    = 2'h1;
  localparam logic [1:0] ST_DONE   = 2'h2;
  localparam logic [1:0] ST_FAULT  = 2'h3;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ   = 100;
  localparam int RETRY_MS  = 2000;
  localparam int CELLOV_MS = 30;
  localparam int PULSE_US  = 128;
  localparam int DETECT_MS = 32;
  localparam int RETRY_CYC  = RETRY_MS * 1000 * CLK_MHZ;
  localparam int CELLOV_CYC = CELLOV_MS * 1000 * CLK_MHZ;
  localparam int PULSE_CYC  = PULSE_US * CLK_MHZ;
  localparam int DETECT_CYC = DETECT_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    S_CHARGE = 3'h0,
    S_UV     = 3'h1,
    S_OVP    = 3'h2,
    S_REVAL  = 3'h3,
    S_DETECT = 3'h4,
    S_DONE   = 3'h5,
    S_ABSENT = 3'h6
  } chg_state_t;
endpackage

/* File: design/charger_limit_fault_logic.sv */
/*
  Supervisory logic of a single-cell switching charger: limit registers
  with write-twice lockable ceilings, thermal, input and cell fault
  handling, cell presence test and status pin pulses.
  Assumes decoded serial-bus register writes and reads, and comparator
  levels synchronous to the clock.
*/
`timescale 1ns/1ns
module charger_limit_fault_logic
  import charger_limit_pkg::*;
#(
  parameter int RETRY_CYCLES  = charger_limit_pkg::RETRY_CYC,
  parameter int CELLOV_CYCLES = charger_limit_pkg::CELLOV_CYC,
  parameter int PULSE_CYCLES  = charger_limit_pkg::PULSE_CYC,
  parameter int DETECT_CYCLES = charger_limit_pkg::DETECT_CYC
)(
  input  wire logic        clock,               // System clock
  input  wire logic        reset,               // Sync reset, high
  input  wire logic        reg_wr,              // Register write strobe
  input  wire logic        reg_rd,              // Register read strobe
  input  wire logic [7:0]  reg_addr,            // Register offset
  input  wire logic [7:0]  reg_wdata,           // Write data
  output logic      [7:0]  reg_rdata,           // Read data
  input  wire logic        vloop_limiting,      // Input loop restricts
  input  wire logic        cell_above_short,    // Cell over short level
  input  wire logic        die_fold_back,       // Die at fold_back_temp
  input  wire logic        die_shutdown,        // Die at shutdown temp
  input  wire logic        input_below_sleep,   // Input < cell + offset
  input  wire logic        input_above_floor,   // Input > floor level
  input  wire logic        input_overvolt,      // Input over OVP level
  input  wire logic        input_ovp_clear,     // Input 100 mV below
  input  wire logic        input_revalidated,   // Input passed checks
  input  wire logic        pwm_pulse,           // Switching pulse seen
  input  wire logic        cell_above_float,    // Cell over float
  input  wire logic        term_reached,        // Near float, low I
  input  wire logic        cell_above_recharge, // Cell > float-drop
  input  wire logic        finish_cutoff_allow, // Termination enable
  input  wire logic        charge_inhibit_n,    // Low allows termination
  input  wire logic        keep_pwm_after_done, // Keep switching
  input  wire logic        status_pin_allow,    // Indicator enable
  input  wire logic [1:0]  input_current_limit_sel, // Input limit
  output logic             input_limit_active,  // Voltage loop limits
  output logic      [12:0] input_floor_mv,      // Floor in mV
  output logic      [10:0] current_ceiling_ma,  // Ceiling in mA
  output logic      [5:0]  float_code,          // Float code in use
  output logic      [10:0] charge_current_ma,   // Current in use
  output logic             switching_on,        // Charger switching
  output logic             input_switch_on,     // Input switch
  output logic             cell_switch_on,      // Cell switch
  output logic             detect_current_on,   // Discharge test
  output logic             sleep_mode,          // Reverse blocked
  output logic             timers_halted,       // Hot suspend
  output logic      [4:0]  precharge_ma,        // Linear current
  output logic      [2:0]  error_code,          // Fault code
  output logic      [1:0]  status_code,         // Status code
  output logic             no_cell_flag,        // Cell absent
  output logic             indicator_out,       // Pin level, low
  output logic             indicator_oe         // Pin driven
);
  import charger_limit_pkg::*;

  localparam logic [27:0] RETRY_M1  = 28'(RETRY_CYCLES - 1);
  localparam logic [27:0] DETECT_M1 = 28'(DETECT_CYCLES - 1);
  localparam logic [21:0] CELLOV_M1 = 22'(CELLOV_CYCLES - 1);
  localparam logic [13:0] PULSE_M1  = 14'(PULSE_CYCLES - 1);

  // ==========================================================
  // Registers and write decode
  logic [7:0] float_r, curr_r, floor_r, ceil_r, pend_r;
  logic       pend_v_r, locked_r, short_prev_r, limact_r;
  chg_state_t state_r, state_nxt;
  logic [27:0] tmr_r;
  wire tmr_done = tmr_r == (state_r == S_DETECT ? DETECT_M1 : RETRY_M1);

  wire wr_float = reg_wr && reg_addr == FLOAT_OFS;
  wire wr_curr  = reg_wr && reg_addr == CURR_OFS;
  wire wr_floor = reg_wr && reg_addr == FLOOR_OFS;
  wire wr_ceil  = reg_wr && reg_addr == CEIL_OFS;
  wire wr_other = reg_wr && reg_addr != CEIL_OFS;
  wire short_rise = cell_above_short && !short_prev_r;
  wire ceil_take  = wr_ceil && !locked_r && pend_v_r
                    && reg_wdata == pend_r;
  wire absent_now = state_r == S_DETECT && !cell_above_recharge
                    && tmr_done;

  // Ceiling decodes
  wire [3:0] iceil = ceil_r[7:ICEIL_LSB];
  wire [3:0] vceil = ceil_r[3:0];
  wire [3:0] imax  = iceil > ICEIL_TOP ? ICEIL_TOP + 4'h1 : iceil;
  wire [5:0] vmax  = VMAX_BASE
                     + {2'b00, vceil >= VCEIL_TOP ? VCEIL_TOP : vceil};

  // Write values after clamping
  wire [5:0] f_in  = reg_wdata[7:FLOAT_LSB];
  wire [3:0] c_in  = reg_wdata[7:CURR_LSB];
  wire [5:0] f_clp = f_in > vmax ? vmax : f_in;
  wire [3:0] c_clp = c_in > iceil ? iceil : c_in;

  always_ff @(posedge clock)
    if (reset || absent_now)
    begin
      float_r <= FLOAT_RST;
      curr_r  <= CURR_RST;
    end
    else
    begin
      if (wr_float)
        float_r <= {f_clp, reg_wdata[FLOAT_LSB-1:0]};
      if (wr_curr)
        curr_r <= {c_clp, reg_wdata[CURR_LSB-1:0]};
    end

  always_ff @(posedge clock)
    if (reset)
    begin
      floor_r      <= FLOOR_RST;
      ceil_r       <= CEIL_RST;
      pend_r       <= 8'h00;
      pend_v_r     <= 1'b0;
      locked_r     <= 1'b0;
      short_prev_r <= 1'b0;
      limact_r     <= 1'b0;
    end
    else
    begin
      short_prev_r <= cell_above_short;
      limact_r     <= vloop_limiting;
      if (wr_floor)
        floor_r <= {5'h00, reg_wdata[2:0]};
      if (short_rise)
      begin
        ceil_r   <= CEIL_RST;
        pend_v_r <= 1'b0;
      end
      else if (ceil_take)
      begin
        ceil_r   <= reg_wdata;
        pend_v_r <= 1'b0;
      end
      else if (wr_ceil && !locked_r)
      begin
        pend_r   <= reg_wdata;
        pend_v_r <= 1'b1;
      end
      else if (wr_other)
        pend_v_r <= 1'b0;
      if (!cell_above_short)
        locked_r <= 1'b0;
      else if (wr_other)
        locked_r <= 1'b1;
    end

  // Read mux; unmapped offsets read zero
  wire [7:0] rd_mux =
    reg_addr == FLOAT_OFS ? float_r :
    reg_addr == CURR_OFS  ? curr_r :
    reg_addr == FLOOR_OFS ? {4'h0, limact_r, floor_r[2:0]} :
    reg_addr == CEIL_OFS  ? ceil_r : 8'h00;

  always_ff @(posedge clock)
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_mux;

  // ==========================================================
  // Decoded levels
  assign input_limit_active = limact_r;
  assign input_floor_mv = FLOOR_BASE_MV
                          + FLOOR_STEP_MV * {10'h000, floor_r[2:0]};
  assign current_ceiling_ma = CURR_BASE_MA
                              + CURR_STEP_MA * {7'h00, imax};
  // Ceiling may be lowered after a write, and codes past the top step
  // must not exceed the top current, so the used value is clamped
  wire [3:0] c_use = curr_r[7:CURR_LSB] > imax ? imax
                     : curr_r[7:CURR_LSB];
  assign float_code = float_r[7:FLOAT_LSB] > vmax ? vmax
                      : float_r[7:FLOAT_LSB];
  assign charge_current_ma = die_fold_back ? FOLD_MA
                             : CURR_BASE_MA + CURR_STEP_MA * {7'h00, c_use};
  assign precharge_ma = cell_above_short ? 5'h00 :
                        input_current_limit_sel < 2'h2 ? PRE_LOW_MA
                        : PRE_HIGH_MA;
  assign sleep_mode = input_below_sleep && input_above_floor;
  assign timers_halted = die_shutdown;

  // ==========================================================
  // Fault sequencing
  logic [21:0] ov_r;
  logic        ov_fired_r, hot_prev_r;
  wire hot_rise = die_shutdown && !hot_prev_r;
  wire ov_evt = state_r == S_CHARGE && !ov_fired_r && ov_r == CELLOV_M1;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      S_CHARGE:
        if (!input_above_floor)
          state_nxt = S_UV;
        else if (finish_cutoff_allow && !charge_inhibit_n && term_reached)
          state_nxt = S_DETECT;
      S_UV:
        if (tmr_done && input_above_floor)
          state_nxt = S_CHARGE;
      S_OVP:
        if (input_ovp_clear)
          state_nxt = S_REVAL;
      S_REVAL:
        if (input_revalidated)
          state_nxt = S_CHARGE;
      S_DETECT:
        if (tmr_done)
          state_nxt = cell_above_recharge ? S_DONE : S_ABSENT;
      S_DONE:
        if (!cell_above_recharge)
          state_nxt = S_CHARGE;
      S_ABSENT:
        if (tmr_done)
          state_nxt = keep_pwm_after_done ? S_DETECT : S_CHARGE;
      default:
        state_nxt = S_CHARGE;
    endcase
    if (input_overvolt)
      state_nxt = S_OVP;
    if (die_shutdown)
      state_nxt = state_r;
  end

  always_ff @(posedge clock)
    if (reset)
    begin
      state_r    <= S_CHARGE;
      tmr_r      <= 28'h0000000;
      hot_prev_r <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      hot_prev_r <= die_shutdown;
      if (state_nxt != state_r)
        tmr_r <= 28'h0000000;
      else if (!die_shutdown && !tmr_done)
        tmr_r <= tmr_r + 28'h0000001;
    end

  // Stall watch: counts only while the cell sits above float unpulsed
  always_ff @(posedge clock)
    if (reset || pwm_pulse || !cell_above_float || state_r != S_CHARGE)
    begin
      ov_r       <= 22'h000000;
      ov_fired_r <= 1'b0;
    end
    else if (ov_evt)
      ov_fired_r <= 1'b1;
    else if (!die_shutdown && !ov_fired_r)
      ov_r <= ov_r + 22'h000001;

  // ==========================================================
  // Error code, flags and indicator pulse
  wire ovp_evt = input_overvolt && state_r != S_OVP;
  wire uv_evt  = state_r == S_CHARGE && !input_above_floor;
  wire fault_evt = hot_rise || ovp_evt || uv_evt || absent_now || ov_evt;
  logic [2:0]  err_nxt;
  logic [13:0] pcnt_r;
  logic        pulse_r, nocell_r, cellov_st_r;

  always_comb
  begin
    err_nxt = error_code;
    if (ov_evt)
      err_nxt = ERR_CELLV;
    if (absent_now)
      err_nxt = ERR_NOCEL;
    if (uv_evt)
      err_nxt = ERR_UV;
    if (ovp_evt)
      err_nxt = ERR_OVP;
    if (hot_rise)
      err_nxt = ERR_HOT;
  end

  always_ff @(posedge clock)
    if (reset)
    begin
      error_code  <= ERR_NONE;
      nocell_r    <= 1'b0;
      cellov_st_r <= 1'b0;
      pulse_r     <= 1'b0;
      pcnt_r      <= 14'h0000;
    end
    else
    begin
      error_code <= err_nxt;
      if (absent_now)
        nocell_r <= 1'b1;
      else if (state_r == S_DONE)
        nocell_r <= 1'b0;
      cellov_st_r <= ov_evt || (cellov_st_r && !pwm_pulse);
      if (fault_evt)
      begin
        pulse_r <= 1'b1;
        pcnt_r  <= 14'h0000;
      end
      else if (pulse_r && pcnt_r == PULSE_M1)
        pulse_r <= 1'b0;
      else if (pulse_r)
        pcnt_r <= pcnt_r + 14'h0001;
    end

  assign no_cell_flag = nocell_r;
  assign indicator_out = 1'b0;
  assign indicator_oe = pulse_r && status_pin_allow;

  // ==========================================================
  // Power path controls and status
  wire fault_st = state_r == S_UV || state_r == S_OVP
                  || state_r == S_REVAL || cellov_st_r;
  assign status_code = fault_st ? ST_FAULT :
                       state_r == S_DONE ? ST_DONE : ST_CHG;
  assign input_switch_on = state_r != S_OVP;
  assign cell_switch_on = state_r != S_DETECT;
  assign detect_current_on = state_r == S_DETECT && !die_shutdown;
  // Switching keeps the system rail up through the presence test
  assign switching_on = !die_shutdown && !sleep_mode && !fault_st
                        && (state_r != S_ABSENT || keep_pwm_after_done);

  // ==========================================================
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  lock_ignore_a: assert property (locked_r && cell_above_short && wr_ceil
    |=> $stable(ceil_r)) else $error("locked ceiling changed");
  twice_take_a: assert property (ceil_take && !short_rise
    |=> ceil_r == $past(reg_wdata)) else $error("repeat write not taken");
  single_wr_a: assert property (wr_ceil && !pend_v_r && !short_rise
    |=> $stable(ceil_r)) else $error("single write took effect");
  clamp_a: assert property (wr_float && !absent_now
    |=> float_r[7:2] <= $past(vmax)) else $error("float above ceiling");
  fold_a: assert property (die_fold_back
    |-> charge_current_ma == 11'h226) else $error("no fold back");
  hot_err_a: assert property ($rose(die_shutdown)
    |=> error_code == 3'h5 ##0 pulse_r) else $error("no thermal fault");
  hot_hold_a: assert property (die_shutdown && hot_prev_r
    |=> $stable(state_r) && $stable(tmr_r)) else $error("state moved hot");
  ovp_a: assert property (input_overvolt && !die_shutdown
    |=> !input_switch_on && status_code == 2'h3 && error_code == 3'h1)
    else $error("over-voltage not handled");
  uv_a: assert property (uv_evt && !input_overvolt && !hot_rise
    |=> error_code == 3'h3 ##0 status_code == 2'h3) else $error("uv missed");
  pulse_len_a: assert property ($fell(pulse_r)
    |-> $past(pcnt_r) == PULSE_M1) else $error("pulse length wrong");
  allow_a: assert property (!status_pin_allow || !pulse_r
    |-> !indicator_oe) else $error("indicator driven when idle");
  pre_a: assert property (!cell_above_short && input_current_limit_sel[1]
    |-> precharge_ma == 5'h1e) else $error("wrong precharge");

  absent_c: cover property (absent_now ##1 state_r == S_ABSENT);
  done_c: cover property (state_r == S_DETECT ##1 state_r == S_DONE);
  ovp_c: cover property (state_r == S_OVP ##1 state_r == S_REVAL);
  take_c: cover property (ceil_take);
endmodule

/* File: verification/charger_host.sv */
/*
  Host model: issues register writes and reads on the strobe bus.
  Assumes the block samples strobes on the rising clock edge.
*/
`timescale 1ns/1ns
module charger_host (
  input  wire logic       clock,     // System clock
  output logic            reg_wr,    // Write strobe
  output logic            reg_rd,    // Read strobe
  output logic      [7:0] reg_addr,  // Register offset
  output logic      [7:0] reg_wdata  // Write data
);
  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  end
  // ==========================================================
  // Bus cycles, changed at the falling edge only
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n);
    @(negedge clock);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    // Held n cycles so a repeated identical write is back to back
    repeat (n - 1) @(negedge clock);
    @(negedge clock);
    reg_wr    = 1'b0;
    // Released data is inverted so stale values never match
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd   = 1'b0;
  endtask
endmodule

/* File: verification/testbench.sv */
/*
  Self-checking bench for the charger supervisory block.
  Assumes short timing parameters; read data is scored from a queue.
*/
`timescale 1ns/1ns
module testbench;
  import charger_limit_pkg::*;
  localparam int RETRY = 50;
  localparam int PULSE = 8;
  localparam int DETECT = 10;
  logic clock, reset, reg_wr, reg_rd, vloop_limiting, cell_above_short, die_fold_back;
  logic die_shutdown, input_below_sleep, input_above_floor, input_overvolt, input_ovp_clear;
  logic input_revalidated, pwm_pulse, cell_above_float, term_reached, cell_above_recharge;
  logic finish_cutoff_allow, charge_inhibit_n, keep_pwm_after_done, status_pin_allow;
  logic input_limit_active, switching_on, input_switch_on, cell_switch_on, detect_current_on;
  logic sleep_mode, timers_halted, no_cell_flag, indicator_out, indicator_oe, rd_seen;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ceil, e, m;
  logic [7:0] exp_q[$], msk_q[$];
  logic pwm_quiet;
  logic [1:0] input_current_limit_sel, status_code;
  logic [12:0] input_floor_mv;
  logic [10:0] current_ceiling_ma, charge_current_ma;
  logic [5:0] float_code, vmax;
  logic [4:0] precharge_ma;
  logic [2:0] error_code;
  int seed, mismatches, total_checks, cycles, pcount, imax;

  charger_host u_host (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  charger_limit_fault_logic #(.RETRY_CYCLES(RETRY), .CELLOV_CYCLES(20),
    .PULSE_CYCLES(PULSE), .DETECT_CYCLES(DETECT)) u_dut (
    .clock, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .vloop_limiting, .cell_above_short, .die_fold_back, .die_shutdown,
    .input_below_sleep, .input_above_floor, .input_overvolt, .input_ovp_clear,
    .input_revalidated, .pwm_pulse, .cell_above_float, .term_reached,
    .cell_above_recharge, .finish_cutoff_allow, .charge_inhibit_n,
    .keep_pwm_after_done, .status_pin_allow, .input_current_limit_sel,
    .input_limit_active, .input_floor_mv, .current_ceiling_ma, .float_code,
    .charge_current_ma, .switching_on, .input_switch_on, .cell_switch_on,
    .detect_current_on, .sleep_mode, .timers_halted, .precharge_ma, .error_code,
    .status_code, .no_cell_flag, .indicator_out, .indicator_oe);

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ==========================================================
  // Scoreboard and watchdog
  always @(posedge clock)
  begin
    rd_seen <= reg_rd;
    cycles <= cycles + 1;
    if (indicator_oe === 1'b1)
      pcount <= pcount + 1;
    if (cycles == 3000)
    begin
      mismatches++;
      conclude();
    end
  end
  always @(negedge clock)
  begin
    pwm_pulse <= pwm_quiet ? 1'b0 : 1'($random(seed));
    if (rd_seen === 1'b1)
    begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      total_checks++;
      if ((reg_rdata & m) !== (e & m))
      begin
        mismatches++;
        $display("unexpected at %0t: read %0h want %0h", $time, reg_rdata, e);
      end
    end
  end
  task automatic rd_expect(input logic [7:0] a, input logic [7:0] x, input logic [7:0] k);
    exp_q.push_back(x);
    msk_q.push_back(k);
    u_host.rd(a);
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] want);
    total_checks++;
    if (got !== want)
    begin
      mismatches++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, want);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    {vloop_limiting, cell_above_short, die_fold_back, die_shutdown, input_below_sleep} = '0;
    {input_overvolt, input_ovp_clear, input_revalidated, pwm_pulse, cell_above_float} = '0;
    {term_reached, finish_cutoff_allow, keep_pwm_after_done, input_current_limit_sel} = '0;
    {input_above_floor, cell_above_recharge, charge_inhibit_n, status_pin_allow} = '1;
    {seed, mismatches, total_checks, cycles, pcount, rd_seen} = '0;
    pwm_quiet = 1'b0;
    seed = 70105;
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    rd_expect(FLOAT_OFS, FLOAT_RST, 8'hff);
    rd_expect(CURR_OFS, CURR_RST, 8'hff);
    rd_expect(FLOOR_OFS, FLOOR_RST, 8'hff);
    rd_expect(CEIL_OFS, CEIL_RST, 8'hff);
    rd_expect(8'h07, 8'h00, 8'hff);
    cell_above_short = 1'b1;
    ceil = $random(seed);
    u_host.wr(CEIL_OFS, ceil, 2);
    rd_expect(CEIL_OFS, ceil, 8'hff);
    vmax = (ceil[3:0] >= VCEIL_TOP) ? 6'h2f : VMAX_BASE + 6'(ceil[3:0]);
    imax = (ceil[7:4] > ICEIL_TOP) ? 10 : int'(ceil[7:4]);
    u_host.wr(FLOAT_OFS, 8'hfc, 1);
    rd_expect(FLOAT_OFS, {vmax, 2'b00}, 8'hfc);
    chk(13'(float_code), 13'(vmax));
    u_host.wr(CURR_OFS, 8'hf0, 1);
    rd_expect(CURR_OFS, {ceil[7:4], 4'h0}, 8'hf0);
    chk(13'(current_ceiling_ma), 13'(550 + 100 * imax));
    chk(13'(charge_current_ma), 13'(550 + 100 * imax));
    die_fold_back = 1'b1;
    @(negedge clock);
    chk(13'(charge_current_ma), 13'(FOLD_MA));
    die_fold_back = 1'b0;
    u_host.wr(CEIL_OFS, ~ceil, 2);
    rd_expect(CEIL_OFS, ceil, 8'hff);
    for (int i = 0; i < 8; i++)
    begin
      u_host.wr(FLOOR_OFS, 8'(i), 1);
      chk(input_floor_mv, 13'(4213 + 80 * i));
    end
    vloop_limiting = 1'b1;
    repeat (2) @(negedge clock);
    chk(13'(input_limit_active), 13'h1);
    rd_expect(FLOOR_OFS, 8'h08, 8'h08);
    vloop_limiting = 1'b0;
    cell_above_short = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      input_current_limit_sel = 2'(i);
      @(negedge clock);
      chk(13'(precharge_ma), (i < 2) ? 13'h00d : 13'h01e);
    end
    cell_above_short = 1'b1;
    @(negedge clock);
    rd_expect(CEIL_OFS, CEIL_RST, 8'hff);
    input_below_sleep = 1'b1;
    @(negedge clock);
    chk(13'(sleep_mode), 13'h1);
    input_below_sleep = 1'b0;
    die_shutdown = 1'b1;
    repeat (2) @(negedge clock);
    chk(13'(error_code), 13'(ERR_HOT));
    chk(13'(timers_halted), 13'h1);
    die_shutdown = 1'b0;
    repeat (3) @(negedge clock);
    pcount = 0;
    input_above_floor = 1'b0;
    repeat (2) @(negedge clock);
    chk(13'(error_code), 13'(ERR_UV));
    chk(13'(status_code), 13'(ST_FAULT));
    input_above_floor = 1'b1;
    repeat (20) @(negedge clock);
    chk(13'(pcount >= PULSE && pcount <= PULSE + 1), 13'h1);
    repeat (RETRY + 5) @(negedge clock);
    chk(13'(status_code), 13'(ST_CHG));
    status_pin_allow = 1'b0;
    pcount = 0;
    input_overvolt = 1'b1;
    repeat (2) @(negedge clock);
    chk(13'(input_switch_on), 13'h0);
    chk(13'(error_code), 13'(ERR_OVP));
    input_overvolt = 1'b0;
    input_ovp_clear = 1'b1;
    input_revalidated = 1'b1;
    repeat (5) @(negedge clock);
    chk(13'(input_switch_on), 13'h1);
    chk(13'(pcount), 13'h0);
    // Switching pulses stop while the cell sits above float
    pwm_quiet = 1'b1;
    cell_above_float = 1'b1;
    repeat (25) @(negedge clock);
    chk(13'(error_code), 13'(ERR_CELLV));
    chk(13'(status_code), 13'(ST_FAULT));
    {pwm_quiet, cell_above_float} = '0;
    {status_pin_allow, finish_cutoff_allow, term_reached} = '1;
    {input_ovp_clear, input_revalidated, charge_inhibit_n, cell_above_recharge} = '0;
    repeat (2) @(negedge clock);
    chk(13'(cell_switch_on), 13'h0);
    chk(13'(detect_current_on), 13'h1);
    term_reached = 1'b0;
    repeat (DETECT + 3) @(negedge clock);
    chk(13'(error_code), 13'(ERR_NOCEL));
    chk(13'(no_cell_flag), 13'h1);
    chk(13'(switching_on), 13'h0);
    keep_pwm_after_done = 1'b1;
    @(negedge clock);
    chk(13'(switching_on), 13'h1);
    rd_expect(FLOAT_OFS, FLOAT_RST, 8'hff);
    // Absence test repeats once the retry interval has run out
    repeat (48) @(negedge clock);
    chk(13'(detect_current_on), 13'h1);
    chk(13'(cell_switch_on), 13'h0);
    chk(13'(indicator_out), 13'h0);
    conclude();
  end
endmodule
